// ### src/axis_orient.sv
`timescale 1ns/1ps
`default_nettype none
// Exchange first, then negate the exchanged axes
module axis_orient #(
  parameter int W = orient_pkg::DW
) (
  input wire logic signed [W-1:0] i_x,
  input wire logic signed [W-1:0] i_y,
  input wire logic i_swap,
  input wire logic i_xneg,
  input wire logic i_yneg,
  output logic signed [W-1:0] o_x,
  output logic signed [W-1:0] o_y
);
  logic signed [W-1:0] sx; // After exchange
  logic signed [W-1:0] sy;
  always_comb begin
    sx = i_swap ? i_y : i_x; // [R01] [R02]
    sy = i_swap ? i_x : i_y;
    o_x = i_xneg ? orient_pkg::neg_sat(sx) : sx; // [R03]
    o_y = i_yneg ? orient_pkg::neg_sat(sy) : sy; // [R04]
  end
endmodule
`default_nettype wire

// ### src/delta_scale.sv
`timescale 1ns/1ps
`default_nettype none
// Scales one raw delta (250 cpi units) to the selected resolution
module delta_scale #(
  parameter int W = orient_pkg::DW
) (
  input wire logic signed [W-1:0] i_delta,
  input wire logic [2:0] i_code,
  output logic signed [W-1:0] o_delta
);
  // Wide product, clipped to the report width
  logic signed [W+3:0] prod;
  localparam logic signed [W+3:0] MAXV = (W+4)'(2**(W-1) - 1);
  localparam logic signed [W+3:0] MINV = -(W+4)'(2**(W-1));
  always_comb begin
    prod = (W+4)'(i_delta) * $signed({1'b0, orient_pkg::res_mult(i_code)}); // [R05]
    if (prod > MAXV) begin
      o_delta = MAXV[W-1:0];
    end else if (prod < MINV) begin
      o_delta = MINV[W-1:0];
    end else begin
      o_delta = prod[W-1:0];
    end
  end
endmodule
`default_nettype wire

// ### src/orient_config.sv
// What this block does
// R01 - Orientation code picks rotation, exchange swaps axes
// R02 - Axis exchange happens before both inversions
// R03 - x_negate set reverses reported X motion
// R04 - y_negate set reverses reported Y motion
// R05 - Resolution codes 2..5 give 500..1250 cpi
// R06 - Product ident: low byte E2, high E3
// R07 - Vendor ident: low byte E4, high E5
// R08 - Writing FF to freeze key locks configuration
// R09 - Zero config_enable bypasses the stored resolution/orientation and idents; the freeze lock still applies
// R10 - Resolution/orientation register resets to 54
// R11 - Motion is scaled and oriented before reporting
`timescale 1ns/1ps
`default_nettype none
module orient_config #(
  parameter logic [15:0] PROD_DEFAULT = 16'hA5C3, // Arbitrary value
  parameter logic [15:0] VEND_DEFAULT = 16'h5A3C  // Arbitrary value
) (
  input wire logic i_clock,
  input wire logic i_rst_n,
  // Avalon-MM slave, word addressed by register index
  input wire orient_pkg::avs_req_t i_avs,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // Raw motion in 250 cpi units, same clock
  input wire orient_pkg::motion_t i_motion,
  output orient_pkg::motion_t o_report,
  output logic [15:0] o_product_ident,
  output logic [15:0] o_vendor_ident,
  output logic o_locked,
  output logic o_config_active
);
  // ****************************************
  // Register storage
  // ****************************************
  logic [7:0] cfg_en_r; // config_enable
  logic [7:0] res_orient_r; // resolution_orientation
  logic [7:0] prod_lo_r; // product_id_low
  logic [7:0] prod_hi_r; // product_id_high
  logic [7:0] vend_lo_r; // vendor_id_low
  logic [7:0] vend_hi_r; // vendor_id_high
  logic [7:0] freeze_r; // config_freeze_key
  logic wait_r; // Drives waitrequest
  logic [31:0] rdata_r; // Drives readdata

  // ****************************************
  // Bus handshake
  // ****************************************
  logic req; // Any request pending
  logic commit; // Edge at which master sees waitrequest low
  logic wr_go; // Write takes effect this edge
  logic frozen; // Configuration locked
  assign req = i_avs.read | i_avs.write;
  assign commit = req & ~wait_r;
  assign wr_go = commit & i_avs.write & i_avs.byteenable[0];
  assign frozen = (freeze_r == orient_pkg::FREEZE_KEY); // [R08]

  // Read mux, unmapped addresses read zero
  function automatic logic [7:0] reg_mux(input logic [7:0] idx);
    unique case (idx)
      orient_pkg::IDX_CFG_EN: reg_mux = cfg_en_r;
      orient_pkg::IDX_RES_ORIENT: reg_mux = res_orient_r;
      orient_pkg::IDX_PROD_LO: reg_mux = prod_lo_r;
      orient_pkg::IDX_PROD_HI: reg_mux = prod_hi_r;
      orient_pkg::IDX_VEND_LO: reg_mux = vend_lo_r;
      orient_pkg::IDX_VEND_HI: reg_mux = vend_hi_r;
      orient_pkg::IDX_FREEZE: reg_mux = freeze_r;
      default: reg_mux = 8'h00;
    endcase
  endfunction

  // One wait cycle per access, then back to waiting
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wait_r <= 1'b1;
    end else if (req && wait_r) begin
      // Request taken: answer in the next cycle
      wait_r <= 1'b0;
    end else begin
      // Answer given or bus idle
      wait_r <= 1'b1;
    end
  end

  // Read data captured while waiting, stands at the answer edge
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata_r <= 32'h0000_0000;
    end else if (i_avs.read && wait_r) begin
      // Sampled at the taking edge, shown during the answer
      rdata_r <= {24'h00_0000, reg_mux(i_avs.address)};
    end else if (commit) begin
      // Cleared so stale data never leaks into a later read
      rdata_r <= 32'h0000_0000;
    end
  end

  // ****************************************
  // Register writes
  // ****************************************
  // Writes to the configuration space are dropped once frozen;
  // the key itself is also frozen so the lock cannot be undone
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cfg_en_r <= orient_pkg::RST_CFG_EN;
      res_orient_r <= orient_pkg::RST_RES_ORIENT; // [R10]
      prod_lo_r <= orient_pkg::RST_ID_BYTE;
      prod_hi_r <= orient_pkg::RST_ID_BYTE;
      vend_lo_r <= orient_pkg::RST_ID_BYTE;
      vend_hi_r <= orient_pkg::RST_ID_BYTE;
      freeze_r <= orient_pkg::RST_FREEZE;
    end else if (wr_go && !frozen) begin // [R08]
      // Only byte lane 0 carries storage
      unique case (i_avs.address)
        orient_pkg::IDX_CFG_EN: cfg_en_r <= i_avs.writedata[7:0];
        orient_pkg::IDX_RES_ORIENT: res_orient_r <= i_avs.writedata[7:0];
        orient_pkg::IDX_PROD_LO: prod_lo_r <= i_avs.writedata[7:0];
        orient_pkg::IDX_PROD_HI: prod_hi_r <= i_avs.writedata[7:0];
        orient_pkg::IDX_VEND_LO: vend_lo_r <= i_avs.writedata[7:0];
        orient_pkg::IDX_VEND_HI: vend_hi_r <= i_avs.writedata[7:0];
        orient_pkg::IDX_FREEZE: freeze_r <= i_avs.writedata[7:0];
        default: ; // Unmapped, ignored
      endcase
    end
  end

  // ****************************************
  // Effective settings
  // ****************************************
  logic cfg_on; // Stored settings in use
  logic [7:0] eff_ro; // Effective resolution/orientation
  logic [2:0] eff_orient;
  logic [2:0] eff_res;
  logic [15:0] eff_prod;
  logic [15:0] eff_vend;
  // Bypass falls back to built-in values, not the stored bytes
  always_comb begin
    cfg_on = (cfg_en_r != 8'h00); // [R09]
    eff_ro = cfg_on ? res_orient_r : orient_pkg::RST_RES_ORIENT; // [R09]
    eff_orient = eff_ro[orient_pkg::POS_ORIENT_HI:orient_pkg::POS_ORIENT_LO]; // [R01]
    eff_res = eff_ro[orient_pkg::POS_RES_HI:orient_pkg::POS_RES_LO]; // [R05]
    eff_prod = cfg_on ? {prod_hi_r, prod_lo_r} : PROD_DEFAULT; // [R06]
    eff_vend = cfg_on ? {vend_hi_r, vend_lo_r} : VEND_DEFAULT; // [R07]
  end

  // ****************************************
  // Motion path
  // ****************************************
  logic signed [orient_pkg::DW-1:0] sc_x; // Scaled
  logic signed [orient_pkg::DW-1:0] sc_y;
  logic signed [orient_pkg::DW-1:0] or_x; // Oriented
  logic signed [orient_pkg::DW-1:0] or_y;

  // Scaling first keeps saturation independent of rotation
  delta_scale #(.W(orient_pkg::DW)) u_scale_x (
    .i_delta(i_motion.dx),
    .i_code(eff_res),
    .o_delta(sc_x)
  );
  delta_scale #(.W(orient_pkg::DW)) u_scale_y (
    .i_delta(i_motion.dy),
    .i_code(eff_res),
    .o_delta(sc_y)
  );
  axis_orient #(.W(orient_pkg::DW)) u_orient (
    .i_x(sc_x),
    .i_y(sc_y),
    .i_swap(eff_ro[orient_pkg::POS_SWAP]),
    .i_xneg(eff_ro[orient_pkg::POS_XNEG]),
    .i_yneg(eff_ro[orient_pkg::POS_YNEG]),
    .o_x(or_x),
    .o_y(or_y)
  );

  // Report register, one cycle behind the raw sample
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_report <= '0;
    end else if (i_motion.valid) begin
      o_report <= '{valid: 1'b1, dx: or_x, dy: or_y}; // [R11]
    end else begin
      o_report.valid <= 1'b0;
    end
  end

  // Identity and status outputs
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_product_ident <= 16'h0000;
      o_vendor_ident <= 16'h0000;
      o_locked <= 1'b0;
      o_config_active <= 1'b0;
    end else begin
      o_product_ident <= eff_prod; // [R06]
      o_vendor_ident <= eff_vend; // [R07]
      o_locked <= frozen; // [R08]
      o_config_active <= cfg_on; // [R09]
    end
  end

  assign o_avs_waitrequest = wait_r;
  assign o_avs_readdata = rdata_r;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_rst_n);

  logic first_r; // High in the first cycle after reset release
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      first_r <= 1'b1;
    end else begin
      first_r <= 1'b0;
    end
  end

  // ****************************************
  // Sequences
  // ****************************************
  // Motion sample with a given orientation code
  sequence s_move(logic [2:0] code);
    i_motion.valid && eff_orient == code;
  endsequence
  // Write of the key to the freeze register
  sequence s_key_write;
    wr_go && i_avs.address == orient_pkg::IDX_FREEZE && i_avs.writedata[7:0] == orient_pkg::FREEZE_KEY;
  endsequence
  // Raw X delta small enough that no scale code clips it
  sequence s_small_dx;
    i_motion.dx < 12'sh100 && i_motion.dx > -12'sh100;
  endsequence
  // Unclipped sample with the axes left alone
  sequence s_plain_move;
    s_move(orient_pkg::ROT_90) and s_small_dx;
  endsequence

  // ****************************************
  // Orientation and scaling
  // ****************************************
  // Zero turn: exchange, then Y negated
  a_rot_zero_map: assert property (s_move(orient_pkg::ROT_0) |=> // [R01]
      o_report.dx == $past(sc_y) && o_report.dy == orient_pkg::neg_sat($past(sc_x)))
    else $error("0 degree mapping wrong");
  // Quarter turn code leaves both axes alone
  a_rot_ninety_map: assert property (s_move(orient_pkg::ROT_90) |=> // [R01]
      o_report.dx == $past(sc_x) && o_report.dy == $past(sc_y))
    else $error("90 degree mapping wrong");
  // Half turn only works if the exchange comes first
  a_swap_before_negate: assert property (s_move(orient_pkg::ROT_180) |=> // [R02]
      o_report.dx == orient_pkg::neg_sat($past(sc_y)) && o_report.dy == $past(sc_x))
    else $error("exchange not applied before inversion");
  // Three quarter turn: both axes negated, no exchange
  a_rot_270_map: assert property (s_move(orient_pkg::ROT_270) |=> // [R01]
      o_report.dx == orient_pkg::neg_sat($past(sc_x)) && o_report.dy == orient_pkg::neg_sat($past(sc_y)))
    else $error("270 degree mapping wrong");
  // X inversion alone
  a_x_negate_only: assert property (i_motion.valid && eff_orient == 3'h2 |=> // [R03]
      o_report.dx == orient_pkg::neg_sat($past(sc_x)) && o_report.dy == $past(sc_y))
    else $error("X inversion wrong");
  // Y inversion alone
  a_y_negate_only: assert property (i_motion.valid && eff_orient == 3'h1 |=> // [R04]
      o_report.dy == orient_pkg::neg_sat($past(sc_y)) && o_report.dx == $past(sc_x))
    else $error("Y inversion wrong");
  // Lowest resolution doubles the raw delta
  a_res_scale_500: assert property ((s_plain_move and eff_res == orient_pkg::RES_500) |=> // [R05]
      o_report.dx == ($past(i_motion.dx) <<< 1))
    else $error("500 cpi scale wrong");
  // Highest resolution multiplies by five
  a_res_scale_1250: assert property ((s_plain_move and eff_res == orient_pkg::RES_1250) |=> // [R05]
      o_report.dx == $past(i_motion.dx) * 12'sd5)
    else $error("1250 cpi scale wrong");
  // Illegal codes behave as the default code
  a_res_fallback: assert property ((s_plain_move and eff_res == 3'h7) |=> // [R05]
      o_report.dx == ($past(i_motion.dx) <<< 2))
    else $error("illegal resolution code not treated as default");

  // ****************************************
  // Report timing
  // ****************************************
  // Report pulse follows every sample by one cycle
  a_report_timing: assert property (o_report.valid == $past(i_motion.valid)) // [R11]
    else $error("report not one cycle after sample");
  // Deltas hold between samples
  a_report_hold: assert property (!i_motion.valid |=> $stable(o_report.dx) && $stable(o_report.dy)) // [R11]
    else $error("report deltas changed without a sample");

  // ****************************************
  // Identity, lock and bypass
  // ****************************************
  // High byte above low byte
  a_product_join: assert property (cfg_on ##1 $stable({prod_hi_r, prod_lo_r}) // [R06]
      |-> o_product_ident == {prod_hi_r, prod_lo_r})
    else $error("product ident byte order wrong");
  // Same order for the vendor pair
  a_vendor_join: assert property (cfg_on ##1 $stable({vend_hi_r, vend_lo_r}) // [R07]
      |-> o_vendor_ident == {vend_hi_r, vend_lo_r})
    else $error("vendor ident byte order wrong");
  // Low product byte lands where it was written
  a_prod_low_store: assert property (wr_go && !frozen && i_avs.address == orient_pkg::IDX_PROD_LO |=> // [R06]
      prod_lo_r == $past(i_avs.writedata[7:0]))
    else $error("product low byte not stored");
  // High vendor byte lands where it was written
  a_vend_high_store: assert property (wr_go && !frozen && i_avs.address == orient_pkg::IDX_VEND_HI |=> // [R07]
      vend_hi_r == $past(i_avs.writedata[7:0]))
    else $error("vendor high byte not stored");
  // Key write freezes, lock output a cycle later
  a_key_locks: assert property ((s_key_write and !frozen) |=> frozen ##1 o_locked) // [R08]
    else $error("key write did not lock");
  // Any unlocked write to the key register is stored
  a_freeze_store: assert property (wr_go && !frozen && i_avs.address == orient_pkg::IDX_FREEZE |=> // [R08]
      freeze_r == $past(i_avs.writedata[7:0]))
    else $error("key register write not stored");
  // Once frozen, a write moves neither the orientation nor the key register
  a_frozen_hold: assert property (frozen && wr_go |=> $stable(res_orient_r) && $stable(freeze_r)) // [R08]
    else $error("write accepted while locked");
  // Lock output trails the key compare by one cycle
  a_locked_follow: assert property (o_locked == $past(frozen)) // [R08]
    else $error("lock output wrong");
  // Skips the reset edges, where the outputs still hold zero
  a_bypass_ident: assert property ((!first_r && cfg_en_r == 8'h00) [*2] |-> o_product_ident == PROD_DEFAULT // [R09]
      && o_vendor_ident == VEND_DEFAULT && !o_config_active)
    else $error("stored settings used while bypassed");
  // Active output trails the enable compare by one cycle
  a_active_follow: assert property (o_config_active == $past(cfg_on)) // [R09]
    else $error("active output wrong");
  // Value straight after reset
  a_reset_orient: assert property (first_r |-> res_orient_r == 8'h54) // [R10]
    else $error("orientation register reset value wrong");

  // ****************************************
  // Register bus
  // ****************************************
  // Exactly one wait cycle per access
  a_bus_answer: assert property (req && wait_r |=> !o_avs_waitrequest ##1 o_avs_waitrequest)
    else $error("bus answer not after one wait cycle");
  // Read data is zero except in the answer cycle
  a_read_idle_zero: assert property (o_avs_waitrequest |-> o_avs_readdata == 32'h0000_0000)
    else $error("read data not cleared outside the answer");
  // A write with byte lane 0 off leaves the stored bytes alone
  a_masked_drop: assert property (commit && i_avs.write && !i_avs.byteenable[0] |=> $stable(prod_lo_r)
      && $stable(res_orient_r) && $stable(cfg_en_r))
    else $error("masked write changed a register");
endmodule
`default_nettype wire

// ### src/orient_pkg.sv
`default_nettype none
package orient_pkg;
  // ****************************************
  // Register indices (byte address = 4 * index)
  // ****************************************
  localparam logic [7:0] IDX_CFG_EN = 8'hDF;
  localparam logic [7:0] IDX_RES_ORIENT = 8'hE0;
  localparam logic [7:0] IDX_PROD_LO = 8'hE2;
  localparam logic [7:0] IDX_PROD_HI = 8'hE3;
  localparam logic [7:0] IDX_VEND_LO = 8'hE4;
  localparam logic [7:0] IDX_VEND_HI = 8'hE5;
  localparam logic [7:0] IDX_FREEZE = 8'hE8;
  // ****************************************
  // Reset values and keys
  // ****************************************
  localparam logic [7:0] RST_CFG_EN = 8'h00;
  localparam logic [7:0] RST_RES_ORIENT = 8'h54;
  localparam logic [7:0] RST_ID_BYTE = 8'h00;
  localparam logic [7:0] RST_FREEZE = 8'h00;
  localparam logic [7:0] FREEZE_KEY = 8'hFF;
  // ****************************************
  // Field positions in resolution_orientation
  // ****************************************
  localparam int POS_SWAP = 6;
  localparam int POS_XNEG = 5;
  localparam int POS_YNEG = 4;
  localparam int POS_RES_HI = 2;
  localparam int POS_RES_LO = 0;
  localparam int POS_ORIENT_HI = 6;
  localparam int POS_ORIENT_LO = 4;
  // Orientation codes {swap, x_neg, y_neg}
  localparam logic [2:0] ROT_0 = 3'h5;
  localparam logic [2:0] ROT_90 = 3'h0;
  localparam logic [2:0] ROT_180 = 3'h6;
  localparam logic [2:0] ROT_270 = 3'h3;
  // Resolution codes, counts per inch = 250 * multiplier
  localparam logic [2:0] RES_500 = 3'h2;
  localparam logic [2:0] RES_750 = 3'h3;
  localparam logic [2:0] RES_1000 = 3'h4;
  localparam logic [2:0] RES_1250 = 3'h5;
  localparam int DW = 12;
  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic valid;
    logic signed [DW-1:0] dx;
    logic signed [DW-1:0] dy;
  } motion_t;
  typedef struct packed {
    logic read;
    logic write;
    logic [7:0] address;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } avs_req_t;
  // Negation clipped so the most negative value stays in range
  function automatic logic signed [DW-1:0] neg_sat(input logic signed [DW-1:0] v);
    neg_sat = (v == {1'b1, {(DW-1){1'b0}}}) ? {1'b0, {(DW-1){1'b1}}} : -v;
  endfunction
  // Multiplier per resolution code; illegal codes fall back to 1000
  function automatic logic [2:0] res_mult(input logic [2:0] code);
    unique case (code)
      RES_500: res_mult = 3'h2;
      RES_750: res_mult = 3'h3;
      RES_1000: res_mult = 3'h4;
      RES_1250: res_mult = 3'h5;
      default: res_mult = 3'h4;
    endcase
  endfunction
endpackage
`default_nettype wire

// ### verification/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  // ****************************************
  // Bench signals
  // ****************************************
  logic i_clock; // 40 MHz clock
  logic i_rst_n; // Async reset, active low
  orient_pkg::avs_req_t avs; // Register bus request
  orient_pkg::motion_t motion; // Raw motion sample
  logic [31:0] rdata; // Bus read data
  logic wait_req; // Bus waitrequest
  orient_pkg::motion_t report; // Oriented motion
  logic [15:0] prod_id; // Effective product ident
  logic [15:0] vend_id; // Effective vendor ident
  logic locked; // Configuration frozen
  logic active; // Stored configuration in use
  int errors; // Mismatch count
  int checks; // Comparison count
  localparam logic [15:0] PROD_DEF = 16'h1234; // Arbitrary value
  localparam logic [15:0] VEND_DEF = 16'hBEEF; // Arbitrary value

  orient_config #(.PROD_DEFAULT(PROD_DEF), .VEND_DEFAULT(VEND_DEF)) orient_config_i (
    .i_clock(i_clock), .i_rst_n(i_rst_n), .i_avs(avs), .o_avs_readdata(rdata),
    .o_avs_waitrequest(wait_req), .i_motion(motion), .o_report(report),
    .o_product_ident(prod_id), .o_vendor_ident(vend_id), .o_locked(locked),
    .o_config_active(active));

  // Free-running clock, half period 12.5 ns
  always #12.5 i_clock = ~i_clock;

  // ****************************************
  // Helpers
  // ****************************************
  // Expected report: scale with clipping, exchange, then negate
  function automatic logic [23:0] xform(input logic [7:0] r, input logic signed [11:0] x,
                                        input logic signed [11:0] y);
    int m;
    int sx;
    int sy;
    logic signed [11:0] ox;
    logic signed [11:0] oy;
    logic signed [11:0] t;
    case (r[2:0])
      3'h2: m = 2;
      3'h3: m = 3;
      3'h5: m = 5;
      default: m = 4;
    endcase
    sx = x * m;
    sy = y * m;
    sx = (sx > 2047) ? 2047 : ((sx < -2048) ? -2048 : sx);
    sy = (sy > 2047) ? 2047 : ((sy < -2048) ? -2048 : sy);
    ox = sx[11:0];
    oy = sy[11:0];
    // Exchange happens before either negation
    if (r[6]) begin
      t = ox;
      ox = oy;
      oy = t;
    end
    if (r[5]) ox = (ox == 12'h800) ? 12'h7FF : -ox;
    if (r[4]) oy = (oy == 12'h800) ? 12'h7FF : -oy;
    return {ox, oy};
  endfunction

  // One comparison, counted, mismatch printed at once
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Wait for the rising edge that samples waitrequest low; read data is taken there
  task automatic await(output logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_clock);
    while (wait_req !== 1'b0 && n < 50) begin
      @(posedge i_clock);
      n++;
    end
    if (n >= 50) begin
      errors++;
      $display("MISMATCH waitrequest expected 0 seen 1");
    end
    d = rdata;
  endtask

  // Bus write, request held until the accepting edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] be = 4'hF);
    logic [31:0] dummy;
    @(posedge i_clock);
    avs <= '{read: 1'b0, write: 1'b1, address: a, writedata: {24'h000000, d}, byteenable: be};
    await(dummy);
    avs.write <= 1'b0;
  endtask

  // Bus read compared against an expected byte
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    logic [31:0] d;
    @(posedge i_clock);
    avs <= '{read: 1'b1, write: 1'b0, address: a, writedata: 32'h00000000, byteenable: 4'hF};
    await(d);
    avs.read <= 1'b0;
    chk($sformatf("reg_%h", a), {24'h000000, exp}, d);
  endtask

  // Let the edge after a write land, then look mid-cycle
  task automatic settle;
    @(posedge i_clock);
    @(negedge i_clock);
  endtask

  // One raw sample in, one-cycle report pulse out
  task automatic mv(input logic [7:0] r, input logic signed [11:0] x, input logic signed [11:0] y);
    @(posedge i_clock);
    motion <= '{valid: 1'b1, dx: x, dy: y};
    @(posedge i_clock);
    motion.valid <= 1'b0;
    @(negedge i_clock);
    chk("report_valid", 32'h1, {31'h0, report.valid});
    chk("report_xy", {8'h00, xform(r, x, y)}, {8'h00, report.dx, report.dy});
    @(negedge i_clock);
    chk("report_pulse", 32'h0, {31'h0, report.valid});
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  // Reset contents, unmapped place, bypass idents
  task automatic t_reset;
    rdchk(8'hDF, 8'h00);
    rdchk(8'hE0, 8'h54);
    rdchk(8'hE2, 8'h00);
    rdchk(8'hE5, 8'h00);
    rdchk(8'hE8, 8'h00);
    rdchk(8'hE1, 8'h00);
    chk("prod_bypass", {16'h0, PROD_DEF}, {16'h0, prod_id});
    chk("vend_bypass", {16'h0, VEND_DEF}, {16'h0, vend_id});
    chk("active", 32'h0, {31'h0, active});
  endtask

  // Stored orientation ignored while bypassed; built-in 54 applies
  task automatic t_bypass;
    mv(8'h54, 12'sd3, 12'sd5);
    wr(8'hE0, 8'h25);
    mv(8'h54, -12'sd7, 12'sd9);
  endtask

  // Every rotation and single inversion against resolution codes 2..5 and illegal code 7, clipping included
  task automatic t_orient;
    logic [2:0] rot [6];
    logic [2:0] res [5];
    logic [7:0] r;
    rot = '{3'h5, 3'h0, 3'h6, 3'h3, 3'h2, 3'h1};
    res = '{3'h2, 3'h3, 3'h4, 3'h5, 3'h7};
    wr(8'hDF, 8'h01);
    settle();
    chk("active", 32'h1, {31'h0, active});
    chk("prod_zero", 32'h0, {16'h0, prod_id});
    for (int i = 0; i < 6; i++) begin
      for (int j = 0; j < 5; j++) begin
        r = {i[0], rot[i], j[0], res[j]};
        wr(8'hE0, r);
        rdchk(8'hE0, r);
        mv(r, 12'sd7, -12'sd3);
        mv(r, -12'sd1000, 12'sd450);
      end
    end
  endtask

  // Ident bytes, masked and unmapped writes
  task automatic t_ident;
    wr(8'hE2, 8'h3C);
    wr(8'hE3, 8'hA1);
    wr(8'hE4, 8'h77);
    wr(8'hE5, 8'h0E);
    wr(8'hE2, 8'hFF, 4'hE);
    wr(8'hE1, 8'h55);
    settle();
    chk("prod_ident", 32'h0000A13C, {16'h0, prod_id});
    chk("vend_ident", 32'h00000E77, {16'h0, vend_id});
    rdchk(8'hE1, 8'h00);
  endtask

  // Only the key freezes; afterwards every write is dropped
  task automatic t_lock;
    wr(8'hE8, 8'h7E);
    settle();
    chk("locked_nokey", 32'h0, {31'h0, locked});
    rdchk(8'hE8, 8'h7E);
    wr(8'hE8, 8'hFF);
    settle();
    chk("locked", 32'h1, {31'h0, locked});
    wr(8'hE2, 8'h00);
    wr(8'hDF, 8'h00);
    settle();
    chk("prod_frozen", 32'h0000A13C, {16'h0, prod_id});
    chk("active_frozen", 32'h1, {31'h0, active});
    rdchk(8'hE2, 8'h3C);
  endtask

  // ****************************************
  // Run control
  // ****************************************
  // Verdict and the single end of the run
  task automatic end_of_test;
    if (errors == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // Main sequence: reset for 4 cycles, then the scenarios
  initial begin
    i_clock = 1'b0;
    i_rst_n = 1'b0;
    avs = '0;
    motion = '0;
    errors = 0;
    checks = 0;
    repeat (4) @(posedge i_clock);
    i_rst_n <= 1'b1;
    t_reset();
    t_bypass();
    t_orient();
    t_ident();
    t_lock();
    end_of_test();
  end

  // Watchdog: the run needs under a thousand cycles, 5000 is ample
  initial begin
    #125000;
    errors++;
    end_of_test();
  end
endmodule
`default_nettype wire
